// >>> hdl/ssc_ctrl.v
// control and status registers of the synchronous serial port (spi / i2c)
//
// Notes on behaviour
// - i2c master: buffer write while bus not ready sets write collision
// - slave: buffer write while still shifting sets write collision, software clears
// - spi slave: byte arriving while buffer full sets overflow, byte dropped unless overwrite enabled
// - i2c: byte received while buffer full sets overflow; software clears
// - spi with port enabled owns clock, out and in pins; select pin only in mode 4
// - i2c with port enabled owns data and clock pins; pins set as inputs
// - spi: polarity bit gives idle clock level, 1 high, 0 low
// - i2c slave: release bit 0 holds bus clock low, 1 releases
// - modes 0-2 spi master div 4/16/64, 3 timer/2, a divider
// - modes 4/5 spi slave; 4 uses select, 5 frees select pin
// - i2c modes 6,7,8,b,e,f decoded; 9,c,d reserved
// - i2c slave with general call enable signals on address zero
// - ack status reads 1 when last byte not acknowledged
// - ack trigger sends ack data bit then clears itself
// - receive trigger clocks in one byte in i2c master
// - stop, restart, start triggers run a condition then self clear
// - i2c slave: control two bit 0 enables clock stretching
// - busy i2c master refuses triggers and buffer writes
// - ack window set on eighth falling edge, cleared on ninth rising
// - stop and start/restart detection signal when enabled
// - spi slave overwrite enable replaces buffer always; overflow still set when full
// - ack window active only with address or data hold enabled
// - i2c slave overwrite: update and ack ignoring overflow when not full
//
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/100ps
`include "ssc_regs.vh"
module ssc_ctrl (
  // system
  input wire mclk,
  input wire rst,
  // wishbone
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_sel_i,
  input wire [7:2] wb_adr_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  // events from shift engine (same clock)
  input wire eng_rx_done,
  input wire [7:0] eng_rx_byte,
  input wire eng_rx_addr,
  input wire eng_tx_busy,
  input wire eng_bus_free,
  input wire eng_ack_valid,
  input wire eng_ack_in,
  input wire eng_fall8,
  input wire eng_rise9,
  input wire eng_start_det,
  input wire eng_stop_det,
  input wire eng_cond_done,
  input wire t2_match,
  // mode decode to engine
  output reg spi_master,
  output reg spi_slave,
  output reg i2c_master,
  output reg i2c_slave,
  output reg engine_idle,
  // pin ownership and clock control
  output reg spi_pins_own,
  output reg slave_select_own,
  output reg i2c_pins_own,
  output reg clk_idle_level,
  output reg bus_clock_hold,
  output reg stretch_en,
  output reg bit_tick,
  // commands to engine
  output reg tx_load,
  output reg [7:0] tx_data,
  output reg cmd_start,
  output reg cmd_restart,
  output reg cmd_stop,
  output reg cmd_receive,
  output reg cmd_ack,
  output reg ack_bit,
  output reg slave_ack_ok,
  // serial event to interrupt controller
  output reg event_pulse
);
  reg [7:0] ctrl1_q;
  reg [7:0] ctrl2_q;
  reg [7:0] ctrl3_q;
  reg [7:0] data_q;
  reg [7:0] div_q;
  reg bf_q;

  wire wr_stb;
  wire rd_stb;
  wire [3:0] reg_idx;
  wire [7:0] wr_data;
  reg [7:0] rd_data;
  wire tick_w;

  wire [3:0] mode;
  wire en;
  wire m_spi_m;
  wire m_spi_s;
  wire m_i2c_m;
  wire m_i2c_s;
  wire m_i2c;
  wire m_ss_int;
  wire trig_busy;
  wire mst_idle;
  wire wr_c1;
  wire wr_c2;
  wire wr_c3;
  wire wr_buf;
  wire write_collision_flag_set;
  wire rx_full;
  wire ovf_set;
  wire buf_upd;
  wire hold_en;
  wire ckp_clr;
  wire gcall;
  wire [4:0] trig_set;

  ssc_wb_slave u_bus (
    .mclk(mclk),
    .rst(rst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .reg_idx(reg_idx),
    .wr_data(wr_data),
    .rd_data(rd_data)
  );

  assign mode = ctrl1_q[3:0];
  assign en = ctrl1_q[`SSC_C1_EN];

  // mode decode; reserved codes match nothing
  assign m_spi_m = (mode <= `SSC_M_SPI_T2) | (mode == `SSC_M_SPI_PRG);
  assign m_spi_s = (mode == `SSC_M_SPI_SS) | (mode == `SSC_M_SPI_NOSS);
  assign m_i2c_m = (mode == `SSC_M_I2C_MST) | (mode == `SSC_M_I2C_FW);
  assign m_i2c_s = (mode == `SSC_M_I2C_S7) | (mode == `SSC_M_I2C_S10) |
                   (mode == `SSC_M_I2C_S7I) | (mode == `SSC_M_I2C_S10I);
  assign m_i2c = m_i2c_m | m_i2c_s;
  assign m_ss_int = (mode == `SSC_M_I2C_S7I) | (mode == `SSC_M_I2C_S10I);

  assign wr_c1 = wr_stb & (reg_idx == `SSC_OFS_CTRL1);
  assign wr_c2 = wr_stb & (reg_idx == `SSC_OFS_CTRL2);
  assign wr_c3 = wr_stb & (reg_idx == `SSC_OFS_CTRL3);
  assign wr_buf = wr_stb & (reg_idx == `SSC_OFS_DATA);

  // master is idle when no trigger is pending and nothing is shifting
  assign trig_busy = |ctrl2_q[`SSC_C2_ACK_SEQUENCE_TRIGGER:`SSC_C2_START];
  assign mst_idle = ~trig_busy & ~eng_tx_busy;

  // write collision: i2c master needs idle engine and free bus, other modes need idle shifter
  assign write_collision_flag_set = wr_buf & en &
                    ((m_i2c_m & (~mst_idle | ~eng_bus_free)) |
                     (~m_i2c_m & eng_tx_busy));

  // receive path
  assign rx_full = eng_rx_done & en & bf_q;
  // spi master never overflows, each transfer is started by software
  assign ovf_set = rx_full & (m_spi_s | m_i2c);
  assign buf_upd = eng_rx_done & en & (
                   m_spi_m |
                   (m_spi_s & (~bf_q | ctrl3_q[`SSC_C3_BUFFER_OVERWRITE_ENABLE])) |
                   (m_i2c_m & ~bf_q) |
                   (m_i2c_s & ~bf_q &
                    (ctrl3_q[`SSC_C3_BUFFER_OVERWRITE_ENABLE] | ~ctrl1_q[`SSC_C1_OVF])));

  // address/data hold: slave drops the release bit after eighth falling edge
  assign hold_en = ctrl3_q[`SSC_C3_ADDRESS_HOLD_ENABLE] | ctrl3_q[`SSC_C3_DATA_HOLD_ENABLE];
  assign ckp_clr = eng_fall8 & en & m_i2c_s &
                   ((eng_rx_addr & ctrl3_q[`SSC_C3_ADDRESS_HOLD_ENABLE]) |
                    (~eng_rx_addr & ctrl3_q[`SSC_C3_DATA_HOLD_ENABLE]));

  assign gcall = eng_rx_done & en & m_i2c_s & eng_rx_addr &
                 (eng_rx_byte == `SSC_GCALL) & ctrl2_q[`SSC_C2_GENERAL_CALL_ENABLE];

  // triggers only accepted by an idle master, never queued
  assign trig_set = (wr_c2 & en & m_i2c_m & mst_idle) ?
                    wr_data[`SSC_C2_ACK_SEQUENCE_TRIGGER:`SSC_C2_START] : 5'h00;

  // control one
  always @(posedge mclk) begin
    if (rst) begin
      ctrl1_q <= `SSC_RST_BYTE;
    end else begin
      if (wr_c1) begin
        ctrl1_q[5:0] <= wr_data[5:0];
        // flags clear on a written zero
        if (~wr_data[`SSC_C1_WRITE_COLLISION_FLAG]) begin
          ctrl1_q[`SSC_C1_WRITE_COLLISION_FLAG] <= 1'b0;
        end
        if (~wr_data[`SSC_C1_OVF]) begin
          ctrl1_q[`SSC_C1_OVF] <= 1'b0;
        end
      end
      // hardware set wins over a clear in the same cycle
      if (write_collision_flag_set) begin
        ctrl1_q[`SSC_C1_WRITE_COLLISION_FLAG] <= 1'b1;
      end
      if (ovf_set) begin
        ctrl1_q[`SSC_C1_OVF] <= 1'b1;
      end
      if (ckp_clr) begin
        ctrl1_q[`SSC_C1_CKP] <= 1'b0;
      end
    end
  end

  // control two
  always @(posedge mclk) begin
    if (rst) begin
      ctrl2_q <= `SSC_RST_BYTE;
    end else begin
      if (wr_c2) begin
        ctrl2_q[`SSC_C2_GENERAL_CALL_ENABLE] <= wr_data[`SSC_C2_GENERAL_CALL_ENABLE];
        ctrl2_q[`SSC_C2_ACK_DATA_VALUE] <= wr_data[`SSC_C2_ACK_DATA_VALUE];
        if (~m_i2c_m) begin
          // outside master mode bit 0 is the stretch enable
          ctrl2_q[`SSC_C2_START] <= wr_data[`SSC_C2_START];
        end
      end
      if (eng_ack_valid) begin
        ctrl2_q[`SSC_C2_ACKST] <= eng_ack_in;
      end
      if (m_i2c_m & eng_cond_done) begin
        // pending triggers all come from one accepted write, so done clears them all
        ctrl2_q[`SSC_C2_ACK_SEQUENCE_TRIGGER:`SSC_C2_START] <= 5'h00;
      end else if (|trig_set) begin
        ctrl2_q[`SSC_C2_ACK_SEQUENCE_TRIGGER:`SSC_C2_START] <= trig_set;
      end
      if (~en & m_i2c_m) begin
        ctrl2_q[`SSC_C2_ACK_SEQUENCE_TRIGGER:`SSC_C2_START] <= 5'h00;
      end
    end
  end

  // control three
  always @(posedge mclk) begin
    if (rst) begin
      ctrl3_q <= `SSC_RST_BYTE;
    end else begin
      if (wr_c3) begin
        ctrl3_q[6:0] <= wr_data[6:0];
      end
      if (~hold_en | ~en | ~m_i2c) begin
        ctrl3_q[`SSC_C3_ACK_WINDOW_STATUS] <= 1'b0;
      end else if (eng_rise9) begin
        ctrl3_q[`SSC_C3_ACK_WINDOW_STATUS] <= 1'b0;
      end else if (eng_fall8) begin
        ctrl3_q[`SSC_C3_ACK_WINDOW_STATUS] <= 1'b1;
      end
    end
  end

  // data buffer, divider and full flag
  always @(posedge mclk) begin
    if (rst) begin
      data_q <= `SSC_RST_BYTE;
      div_q <= `SSC_RST_BYTE;
      bf_q <= 1'b0;
    end else begin
      if (wr_stb & (reg_idx == `SSC_OFS_DIV)) begin
        div_q <= wr_data;
      end
      if (wr_buf & ~write_collision_flag_set) begin
        data_q <= wr_data;
      end
      if (buf_upd) begin
        data_q <= eng_rx_byte;
        bf_q <= 1'b1;
      end else if (rd_stb & (reg_idx == `SSC_OFS_DATA)) begin
        bf_q <= 1'b0;
      end
      if (~en) begin
        bf_q <= 1'b0;
      end
    end
  end

  always @* begin
    case (reg_idx)
      `SSC_OFS_CTRL1: rd_data = ctrl1_q;
      `SSC_OFS_CTRL2: rd_data = ctrl2_q;
      `SSC_OFS_CTRL3: rd_data = ctrl3_q;
      `SSC_OFS_DATA: rd_data = data_q;
      `SSC_OFS_DIV: rd_data = div_q;
      `SSC_OFS_STAT: rd_data = {6'h00, ~mst_idle, bf_q};
      default: rd_data = 8'h00;
    endcase
  end

  // divider only runs while a master mode is enabled
  ssc_clkdiv u_div (
    .mclk(mclk),
    .rst(rst),
    .run(en & (m_spi_m | m_i2c_m)),
    .mode(mode),
    .reload(div_q),
    .t2_match(t2_match),
    .tick(tick_w)
  );

  // registered outputs to engine and pads
  always @(posedge mclk) begin
    if (rst) begin
      spi_master <= 1'b0;
      spi_slave <= 1'b0;
      i2c_master <= 1'b0;
      i2c_slave <= 1'b0;
      engine_idle <= 1'b1;
      spi_pins_own <= 1'b0;
      slave_select_own <= 1'b0;
      i2c_pins_own <= 1'b0;
      clk_idle_level <= 1'b0;
      bus_clock_hold <= 1'b0;
      stretch_en <= 1'b0;
      bit_tick <= 1'b0;
      tx_load <= 1'b0;
      tx_data <= `SSC_RST_BYTE;
      cmd_start <= 1'b0;
      cmd_restart <= 1'b0;
      cmd_stop <= 1'b0;
      cmd_receive <= 1'b0;
      cmd_ack <= 1'b0;
      ack_bit <= 1'b0;
      slave_ack_ok <= 1'b0;
      event_pulse <= 1'b0;
    end else begin
      spi_master <= en & m_spi_m;
      spi_slave <= en & m_spi_s;
      i2c_master <= en & m_i2c_m;
      i2c_slave <= en & m_i2c_s;
      engine_idle <= ~en | ~(m_spi_m | m_spi_s | m_i2c);
      spi_pins_own <= en & (m_spi_m | m_spi_s);
      // mode 5 leaves the select pin to general i/o
      slave_select_own <= en & (mode == `SSC_M_SPI_SS);
      // pads are inputs by default, so open drain works once owned
      i2c_pins_own <= en & m_i2c;
      clk_idle_level <= ctrl1_q[`SSC_C1_CKP];
      bus_clock_hold <= en & m_i2c_s & ~ctrl1_q[`SSC_C1_CKP];
      stretch_en <= en & m_i2c_s & ctrl2_q[`SSC_C2_START];
      bit_tick <= tick_w;
      tx_load <= wr_buf & en & ~write_collision_flag_set;
      if (wr_buf & ~write_collision_flag_set) begin
        tx_data <= wr_data;
      end
      cmd_start <= trig_set[`SSC_C2_START];
      cmd_restart <= trig_set[`SSC_C2_RSTRT];
      cmd_stop <= trig_set[`SSC_C2_STOP];
      cmd_receive <= trig_set[`SSC_C2_RECEIVE_TRIGGER];
      cmd_ack <= trig_set[`SSC_C2_ACK_SEQUENCE_TRIGGER];
      ack_bit <= ctrl2_q[`SSC_C2_ACK_DATA_VALUE];
      // slave acknowledges only a byte that reached the buffer
      slave_ack_ok <= buf_upd & m_i2c_s;
      event_pulse <= gcall |
                     (en & m_i2c & eng_stop_det &
                      (ctrl3_q[`SSC_C3_PCIE] | m_ss_int)) |
                     (en & m_i2c & eng_start_det &
                      (ctrl3_q[`SSC_C3_START_INTERRUPT_ENABLE] | m_ss_int));
    end
  end
endmodule

// >>> common/ssc_regs.vh
// register offsets, field positions, mode codes and reset values of the serial port control
`ifndef SSC_REGS_VH
`define SSC_REGS_VH

`define SSC_OFS_CTRL1 4'h0
`define SSC_OFS_CTRL2 4'h1
`define SSC_OFS_CTRL3 4'h2
`define SSC_OFS_DATA 4'h3
`define SSC_OFS_DIV 4'h4
`define SSC_OFS_STAT 4'h5

`define SSC_C1_WRITE_COLLISION_FLAG 7
`define SSC_C1_OVF 6
`define SSC_C1_EN 5
`define SSC_C1_CKP 4
`define SSC_C2_GENERAL_CALL_ENABLE 7
`define SSC_C2_ACKST 6
`define SSC_C2_ACK_DATA_VALUE 5
`define SSC_C2_ACK_SEQUENCE_TRIGGER 4
`define SSC_C2_RECEIVE_TRIGGER 3
`define SSC_C2_STOP 2
`define SSC_C2_RSTRT 1
`define SSC_C2_START 0
`define SSC_C3_ACK_WINDOW_STATUS 7
`define SSC_C3_PCIE 6
`define SSC_C3_START_INTERRUPT_ENABLE 5
`define SSC_C3_BUFFER_OVERWRITE_ENABLE 4
`define SSC_C3_ADDRESS_HOLD_ENABLE 1
`define SSC_C3_DATA_HOLD_ENABLE 0

`define SSC_M_SPI_D4 4'h0
`define SSC_M_SPI_D16 4'h1
`define SSC_M_SPI_D64 4'h2
`define SSC_M_SPI_T2 4'h3
`define SSC_M_SPI_SS 4'h4
`define SSC_M_SPI_NOSS 4'h5
`define SSC_M_I2C_S7 4'h6
`define SSC_M_I2C_S10 4'h7
`define SSC_M_I2C_MST 4'h8
`define SSC_M_RSV9 4'h9
`define SSC_M_SPI_PRG 4'ha
`define SSC_M_I2C_FW 4'hb
`define SSC_M_RSVC 4'hc
`define SSC_M_RSVD 4'hd
`define SSC_M_I2C_S7I 4'he
`define SSC_M_I2C_S10I 4'hf

`define SSC_DIV4 8'h04
`define SSC_DIV16 8'h10
`define SSC_DIV64 8'h40
`define SSC_RST_BYTE 8'h00
`define SSC_GCALL 8'h00

`endif

// >>> hdl/ssc_wb_slave.v
// classic wishbone slave front end: one wait state, registered ack and read data
`timescale 1ns/100ps
module ssc_wb_slave (
  // system
  input wire mclk,
  input wire rst,
  // wishbone
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_sel_i,
  input wire [7:2] wb_adr_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // register file side
  output wire wr_stb,
  output wire rd_stb,
  output wire [3:0] reg_idx,
  output wire [7:0] wr_data,
  input wire [7:0] rd_data
);
  wire req;
  wire hit;

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // only lane 0 carries data; upper lanes are ignored on write
  assign hit = (wb_adr_i[7:6] == 2'b00);
  assign reg_idx = wb_adr_i[5:2];
  assign wr_stb = req & wb_we_i & wb_sel_i[0] & hit;
  assign rd_stb = req & ~wb_we_i & hit;
  assign wr_data = wb_dat_i[7:0];

  always @(posedge mclk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      if (req & ~wb_we_i) begin
        wb_dat_o <= hit ? {24'h000000, rd_data} : 32'h00000000;
      end
    end
  end
endmodule

// >>> hdl/ssc_clkdiv.v
// bit-rate tick generator for the master modes
`timescale 1ns/100ps
`include "ssc_regs.vh"
module ssc_clkdiv (
  // system
  input wire mclk,
  input wire rst,
  // control
  input wire run,
  input wire [3:0] mode,
  input wire [7:0] reload,
  input wire t2_match,
  // tick out
  output reg tick
);
  reg [9:0] cnt_q;
  reg t2_half_q;
  reg [9:0] period;

  always @* begin
    case (mode)
      `SSC_M_SPI_D4: period = {2'b00, `SSC_DIV4};
      `SSC_M_SPI_D16: period = {2'b00, `SSC_DIV16};
      `SSC_M_SPI_D64: period = {2'b00, `SSC_DIV64};
      default: period = {reload, 2'b00} + 10'h004;
    endcase
  end

  always @(posedge mclk) begin
    if (rst | ~run) begin
      cnt_q <= 10'h000;
      t2_half_q <= 1'b0;
      tick <= 1'b0;
    end else if (mode == `SSC_M_SPI_T2) begin
      // timer match divided by two
      if (t2_match) begin
        t2_half_q <= ~t2_half_q;
      end
      tick <= t2_match & t2_half_q;
    end else if (cnt_q >= period - 10'h001) begin
      cnt_q <= 10'h000;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 10'h001;
      tick <= 1'b0;
    end
  end
endmodule

// >>> dv/ssc_ctrl_checker.sv
// port assertions for the serial port control block
`timescale 1ns/100ps
module ssc_ctrl_checker (
  // system
  input wire logic mclk,
  input wire logic rst,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [7:2] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // engine events
  input wire logic eng_rx_done,
  input wire logic eng_start_det,
  input wire logic eng_stop_det,
  // decode and control
  input wire logic spi_slave,
  input wire logic i2c_master,
  input wire logic i2c_slave,
  input wire logic engine_idle,
  input wire logic spi_pins_own,
  input wire logic slave_select_own,
  input wire logic i2c_pins_own,
  input wire logic clk_idle_level,
  input wire logic bus_clock_hold,
  input wire logic cmd_start,
  input wire logic cmd_stop,
  input wire logic event_pulse
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // the acked write to control one, seen at the edge where ack is sampled
  sequence wr1_s;
    wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 6'h00;
  endsequence
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_wait_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:6] != 2'b00
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  off_idle_a: assert property (wr1_s ##0 !wb_dat_i[5]
    |=> engine_idle && !spi_pins_own && !i2c_pins_own) else $error("pins kept when off");
  rsv_idle_a: assert property (wr1_s ##0 (wb_dat_i[5] &&
    wb_dat_i[3:0] inside {4'h9, 4'hc, 4'hd}) |=> engine_idle && !spi_pins_own && !i2c_pins_own)
    else $error("reserved mode not idle");
  polarity_a: assert property (wr1_s |=> clk_idle_level == $past(wb_dat_i[4]))
    else $error("idle level differs from written bit");
  select_own_a: assert property (slave_select_own |-> spi_slave)
    else $error("select pin owned outside slave mode");
  clock_hold_a: assert property (bus_clock_hold |-> i2c_slave && !clk_idle_level)
    else $error("bus clock held wrongly");
  cmd_master_a: assert property (cmd_start || cmd_stop |-> i2c_master)
    else $error("bus condition outside master mode");
  event_cause_a: assert property (event_pulse |-> $past(eng_start_det) ||
    $past(eng_stop_det) || $past(eng_rx_done)) else $error("event without cause");
endmodule

bind ssc_ctrl ssc_ctrl_checker chk (.*);

// >>> dv/ssc_eng_model.sv
// shift engine stand-in: finishes every bus condition after a fixed delay
`timescale 1ns/100ps
module ssc_eng_model #(parameter int DLY = 20) (
  // system
  input wire logic mclk,
  input wire logic rst,
  // commands in, completion out
  input wire logic [4:0] cmd,
  output logic done
);
  int cnt = 0;
  initial done = 1'b0;
  always @(posedge mclk) begin
    done <= 1'b0;
    if (rst)
      cnt <= 0;
    else if (cnt == 1) begin
      cnt <= 0;
      done <= 1'b1;
    end else if (cnt > 1)
      cnt <= cnt - 1;
    else if (|cmd)
      cnt <= DLY;
  end
endmodule

// >>> dv/tb_ssc_ctrl.sv
// self-checking bench for the serial port control registers
`timescale 1ns/100ps
module tb_ssc_ctrl;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [5:0] ev = 6'h00;
  logic [7:0] rx_b = 8'h00;
  logic rx_adr = 1'b0, busy = 1'b0, free = 1'b1, ack_in = 1'b0, t2 = 1'b0;
  logic ack, sm, ss, im, isl, idle, spo, sso, ipo, cil, hold, st, ab, done, evp;
  logic [4:0] cmd;
  int bad_count = 0, num_checks = 0, ev_cnt = 0, cmd_cnt = 0;
  always #20 mclk = ~mclk;
  ssc_ctrl uut (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_sel_i(4'h1), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .eng_rx_done(ev[0]), .eng_rx_byte(rx_b), .eng_rx_addr(rx_adr), .eng_tx_busy(busy),
    .eng_bus_free(free), .eng_ack_valid(ev[1]), .eng_ack_in(ack_in), .eng_fall8(ev[2]),
    .eng_rise9(ev[3]), .eng_start_det(ev[4]), .eng_stop_det(ev[5]), .eng_cond_done(done),
    .t2_match(t2), .spi_master(sm), .spi_slave(ss), .i2c_master(im), .i2c_slave(isl),
    .engine_idle(idle), .spi_pins_own(spo), .slave_select_own(sso), .i2c_pins_own(ipo),
    .clk_idle_level(cil), .bus_clock_hold(hold), .stretch_en(st), .bit_tick(), .tx_load(),
    .tx_data(), .cmd_start(cmd[0]), .cmd_restart(cmd[1]), .cmd_stop(cmd[2]),
    .cmd_receive(cmd[3]), .cmd_ack(cmd[4]), .ack_bit(ab), .slave_ack_ok(),
    .event_pulse(evp));
  ssc_eng_model #(.DLY(20)) eng (.mclk(mclk), .rst(rst), .cmd(cmd), .done(done));
  always @(posedge mclk) begin
    ev_cnt <= ev_cnt + int'(evp);
    cmd_cnt <= cmd_cnt + int'(|cmd);
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one classic cycle; waits on ack, never on a fixed count
  task automatic bus(input logic [5:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    if (n >= 50) begin
      bad_count++;
      report_and_stop();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    chk(q, {24'h0, e});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // one-cycle engine event, byte presented with it
  task automatic fire(input logic [5:0] m, input logic [7:0] b);
    @(posedge mclk);
    ev <= m;
    rx_b <= b;
    @(posedge mclk);
    ev <= 6'h00;
    tick(3);
  endtask
  function automatic logic [7:0] mexp(input logic [3:0] m);
    case (m)
      4'h0, 4'h1, 4'h2, 4'h3, 4'ha: mexp = 8'h82;
      4'h4: mexp = 8'h62;
      4'h5: mexp = 8'h42;
      4'h8, 4'hb: mexp = 8'h11;
      4'h9, 4'hc, 4'hd: mexp = 8'h04;
      default: mexp = 8'h09;
    endcase
  endfunction
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++)
      rd(i[5:0], 8'h00);
    wr(6'h20, 8'hff);
    rd(6'h20, 8'h00);
    rd(6'h00, 8'h00);
    for (int m = 0; m < 16; m++) begin
      wr(6'h00, {3'b001, m[0], m[3:0]});
      tick(2);
      chk({sm, ss, sso, im, isl, idle, spo, ipo}, mexp(m[3:0]));
      chk({cil, hold}, {m[0], m == 6 || m == 14});
      rd(6'h00, {3'b001, m[0], m[3:0]});
    end
    wr(6'h00, 8'h00);
    tick(2);
    chk({sm, ss, sso, im, isl, idle, spo, ipo}, 8'h04);
    wr(6'h00, 8'h20);
    fire(6'h01, 8'h55);
    fire(6'h01, 8'h66);
    rd(6'h00, 8'h20);
    rd(6'h03, 8'h66);
    wr(6'h00, 8'h24);
    fire(6'h01, 8'h11);
    fire(6'h01, 8'h22);
    rd(6'h00, 8'h64);
    rd(6'h03, 8'h11);
    wr(6'h00, 8'h24);
    wr(6'h02, 8'h10);
    fire(6'h01, 8'h33);
    fire(6'h01, 8'h44);
    rd(6'h03, 8'h44);
    wr(6'h00, 8'h24);
    @(posedge mclk);
    busy <= 1'b1;
    wr(6'h03, 8'h77);
    rd(6'h00, 8'ha4);
    busy <= 1'b0;
    wr(6'h02, 8'h00);
    wr(6'h04, 8'h09);
    rd(6'h04, 8'h09);
    wr(6'h00, 8'h28);
    for (int i = 0; i < 5; i++) begin
      wr(6'h01, 8'h20 | (8'h01 << i));
      rd(6'h01, 8'h20 | (8'h01 << i));
      if (i == 0) begin
        wr(6'h01, 8'h24);
        rd(6'h01, 8'h21);
      end
      tick(30);
      rd(6'h01, 8'h20);
      chk(cmd_cnt, i + 1);
    end
    chk(ab, 1'b1);
    @(posedge mclk);
    ack_in <= 1'b1;
    fire(6'h02, 8'h00);
    rd(6'h01, 8'h60);
    ack_in <= 1'b0;
    fire(6'h02, 8'h00);
    rd(6'h01, 8'h20);
    free <= 1'b0;
    wr(6'h03, 8'ha5);
    rd(6'h00, 8'ha8);
    wr(6'h00, 8'h28);
    rd(6'h00, 8'h28);
    free <= 1'b1;
    wr(6'h00, 8'h26);
    wr(6'h01, 8'h01);
    tick(2);
    chk(st, 1'b1);
    fire(6'h04, 8'h00);
    rd(6'h02, 8'h00);
    wr(6'h02, 8'h61);
    fire(6'h04, 8'h00);
    rd(6'h02, 8'he1);
    fire(6'h08, 8'h00);
    rd(6'h02, 8'h61);
    fire(6'h20, 8'h00);
    fire(6'h10, 8'h00);
    chk(ev_cnt, 2);
    wr(6'h02, 8'h01);
    fire(6'h20, 8'h00);
    chk(ev_cnt, 2);
    wr(6'h01, 8'h81);
    rx_adr <= 1'b1;
    fire(6'h01, 8'h00);
    chk(ev_cnt, 3);
    wr(6'h01, 8'h01);
    fire(6'h01, 8'h00);
    chk(ev_cnt, 3);
    report_and_stop();
  end
endmodule
